// ### rtl/diag_bank_pkg.sv
package diag_bank_pkg;

  // ----------------------------------------
  // Serial link
  // ----------------------------------------
  localparam logic [6:0] DEV_ADDR = 7'h51;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // ----------------------------------------
  // Byte map of the page
  // ----------------------------------------
  localparam logic [7:0] THR_LAST = 8'h27;
  localparam logic [7:0] CAL_FIRST = 8'h38;
  localparam logic [7:0] CAL_LAST = 8'h5e;
  localparam logic [7:0] OFS_CHECKSUM = 8'h5f;
  localparam logic [7:0] MON_FIRST = 8'h60;
  localparam logic [7:0] MON_LAST = 8'h69;
  localparam logic [7:0] OFS_SOFT_COMMAND_STATUS = 8'h6e;
  localparam logic [7:0] OFS_ALARM_FLAGS_A = 8'h70;
  localparam logic [7:0] OFS_ALARM_FLAGS_B = 8'h71;
  localparam logic [7:0] OFS_TX_INPUT_EQUALIZATION = 8'h72;
  localparam logic [7:0] OFS_RX_OUTPUT_EMPHASIS = 8'h73;
  localparam logic [7:0] OFS_WARNING_FLAGS_A = 8'h74;
  localparam logic [7:0] OFS_WARNING_FLAGS_B = 8'h75;
  localparam logic [7:0] OFS_EXTENDED_SOFT_CONTROL = 8'h76;
  localparam logic [7:0] OFS_CLOCK_RECOVERY_LOCK_STATUS = 8'h77;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_TX_OFF_PIN = 7;
  localparam int BIT_SOFT_TX_OFF = 6;
  localparam int BIT_TX_RATE_PIN = 5;
  localparam int BIT_RX_RATE_PIN = 4;
  localparam int BIT_SOFT_RX_RATE = 3;
  localparam int BIT_TX_FAULT = 2;
  localparam int BIT_SIGNAL_LOSS = 1;
  localparam int BIT_READY_N = 0;
  localparam int BIT_SOFT_TX_RATE = 3;
  localparam int BIT_POWER_STATE = 1;
  localparam int BIT_TX_LOCK_LOST = 1;
  localparam int BIT_RX_LOCK_LOST = 0;
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 4;

  // ----------------------------------------
  // Codes and reset values
  // ----------------------------------------
  localparam logic [3:0] EQ_CODE_MAX = 4'ha;
  localparam logic [7:0] CAL_DEFAULT = 8'h00;
  localparam logic [7:0] CHECKSUM_DEFAULT = 8'h00;
  localparam logic [7:0] THR_RESET = 8'h00;
  localparam logic [3:0] CODE_RESET = 4'h0;
  localparam logic SOFT_RESET = 1'b0;

  // ----------------------------------------
  // Monitor channels
  // ----------------------------------------
  localparam int NUM_MON = 5;
  localparam int THR_BYTES_PER_MON = 8;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_DEV = 4'b0001,
    ST_DEV_ACK = 4'b0010,
    ST_SUB = 4'b0011,
    ST_SUB_ACK = 4'b0100,
    ST_WDATA = 4'b0101,
    ST_WACK = 4'b0110,
    ST_RDATA = 4'b0111,
    ST_RACK = 4'b1000
  } link_state_t;

endpackage

// ### rtl/diag_bank.sv
// Function
// - Temperature reads signed 16-bit, 1/256 degree steps
// - Optical powers read unsigned 16-bit, 0.1 uW steps
// - Supply voltage reads unsigned 16-bit value
// - Bias current reads unsigned 16-bit, 2 uA
// - Status bit 7 mirrors transmitter-disable pin
// - Status bit 6 soft disable, ORed with pin
// - Status bits 5,4 mirror rate pins
// - Status bit 3 soft receive rate, ORed
// - Status bits 2,1 mirror fault and loss
// - Status bit 0 reads 0 when data ready
// - Soft control changes act within 100 ms
// - Byte 112 holds eight alarm flags
// - Byte 113 holds receive power alarms
// - Warning bytes mirror alarm byte layout
// - Byte 118 bit 3 soft transmit rate
// - Byte 118 power state reads zero
// - Byte 119 reports clock recovery lock loss
// - Byte 114 high nibble input equalizer code
// - Byte 115 high nibble output boost code
// - Calibration bytes hold fixed defaults
// - Byte 95 holds stored checksum
// - Monitor values at 96-105, MSB first
module diag_bank
  import diag_bank_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic SCL_IN,
  input wire logic SDA_IN,
  output logic SDA_OUT,
  output logic SDA_OE_OUT,
  input wire logic TX_OFF_PIN_IN,
  input wire logic TRANSMIT_RATE_CHOICE_IN,
  input wire logic RECEIVE_RATE_CHOICE_IN,
  input wire logic TX_FAULT_IN,
  input wire logic SIGNAL_LOSS_OUTPUT_IN,
  input wire logic MON_VALID_IN,
  input wire logic TX_LOCK_LOST_FLAG_IN,
  input wire logic RX_LOCK_LOST_FLAG_IN,
  input wire logic [15:0] MON_TEMP_IN,
  input wire logic [15:0] MON_VCC_IN,
  input wire logic [15:0] MON_BIAS_IN,
  input wire logic [15:0] MON_TX_POWER_IN,
  input wire logic [15:0] MON_RX_POWER_IN,
  output logic TX_OFF_OUT,
  output logic TX_HIGH_RATE_OUT,
  output logic RX_HIGH_RATE_OUT,
  output logic [3:0] INPUT_EQUALIZER_CODE_OUT,
  output logic [3:0] OUTPUT_BOOST_CODE_OUT
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [4:0] sync1;
  logic [4:0] sync2;
  logic scl_d;
  logic sda_d;
  logic scl;
  logic sda;
  logic pin_tx_off;
  logic pin_tx_rate;
  logic pin_rx_rate;

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      sync1 <= 5'h18;
      sync2 <= 5'h18;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else if (CE_IN)
    begin
      sync1 <= {SCL_IN, SDA_IN, TX_OFF_PIN_IN, TRANSMIT_RATE_CHOICE_IN, RECEIVE_RATE_CHOICE_IN};
      sync2 <= sync1;
      scl_d <= sync2[4];
      sda_d <= sync2[3];
    end
  end

  assign scl = sync2[4];
  assign sda = sync2[3];
  assign pin_tx_off = sync2[2];
  assign pin_tx_rate = sync2[1];
  assign pin_rx_rate = sync2[0];

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;

  assign scl_rise = scl & ~scl_d;
  assign scl_fall = ~scl & scl_d;
  assign start_cond = scl & scl_d & sda_d & ~sda;
  assign stop_cond = scl & scl_d & ~sda_d & sda;

  // ----------------------------------------
  // Monitor values
  // ----------------------------------------
  logic [15:0] mon [0:NUM_MON-1];

  assign mon[0] = MON_TEMP_IN;
  assign mon[1] = MON_VCC_IN;
  assign mon[2] = MON_BIAS_IN;
  assign mon[3] = MON_TX_POWER_IN;
  assign mon[4] = MON_RX_POWER_IN;

  // ----------------------------------------
  // Threshold store and flag compare
  // ----------------------------------------
  logic [7:0] thr [0:39];
  logic [9:0] next_alarm;
  logic [9:0] next_warn;
  logic [9:0] alarm;
  logic [9:0] warn;

  genvar q;
  generate
    for (q = 0; q < NUM_MON; q = q + 1)
    begin : g_cmp
      localparam int B = q * THR_BYTES_PER_MON;
      logic [15:0] hi_a;
      logic [15:0] lo_a;
      logic [15:0] hi_w;
      logic [15:0] lo_w;
      assign hi_a = {thr[B], thr[B+1]};
      assign lo_a = {thr[B+2], thr[B+3]};
      assign hi_w = {thr[B+4], thr[B+5]};
      assign lo_w = {thr[B+6], thr[B+7]};
      if (q == 0)
      begin : g_signed
        assign next_alarm[9-2*q] = $signed(mon[q]) > $signed(hi_a);
        assign next_alarm[8-2*q] = $signed(mon[q]) < $signed(lo_a);
        assign next_warn[9-2*q] = $signed(mon[q]) > $signed(hi_w);
        assign next_warn[8-2*q] = $signed(mon[q]) < $signed(lo_w);
      end
      else
      begin : g_unsigned
        assign next_alarm[9-2*q] = mon[q] > hi_a;
        assign next_alarm[8-2*q] = mon[q] < lo_a;
        assign next_warn[9-2*q] = mon[q] > hi_w;
        assign next_warn[8-2*q] = mon[q] < lo_w;
      end
    end
  endgenerate

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      alarm <= 10'h000;
      warn <= 10'h000;
    end
    else if (CE_IN)
    begin
      alarm <= next_alarm;
      warn <= next_warn;
    end
  end

  // ----------------------------------------
  // Serial link state
  // ----------------------------------------
  link_state_t st;
  logic [3:0] cnt;
  logic [7:0] shreg;
  logic [7:0] txsh;
  logic [7:0] ptr;
  logic rw;
  logic wr_pulse;
  logic [7:0] rd_byte;

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      st <= ST_IDLE;
      cnt <= 4'h0;
      shreg <= 8'h00;
      txsh <= 8'h00;
      ptr <= 8'h00;
      rw <= 1'b0;
      wr_pulse <= 1'b0;
      SDA_OE_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      wr_pulse <= 1'b0;
      if (start_cond)
      begin
        st <= ST_DEV;
        cnt <= 4'h0;
        SDA_OE_OUT <= 1'b0;
      end
      else if (stop_cond)
      begin
        st <= ST_IDLE;
        SDA_OE_OUT <= 1'b0;
      end
      else if (scl_rise)
      begin
        case (st)
          ST_DEV, ST_SUB, ST_WDATA, ST_RDATA:
          begin
            shreg <= {shreg[6:0], sda};
            cnt <= cnt + 4'h1;
          end
          ST_RACK:
          begin
            shreg <= {shreg[6:0], sda};
          end
          default:
          begin
            cnt <= cnt;
          end
        endcase
      end
      else if (scl_fall)
      begin
        case (st)
          ST_DEV:
          begin
            if (cnt == BITS_PER_BYTE)
            begin
              if (shreg[7:1] == DEV_ADDR)
              begin
                st <= ST_DEV_ACK;
                rw <= shreg[0];
                SDA_OE_OUT <= 1'b1;
              end
              else
              begin
                st <= ST_IDLE;
              end
            end
          end
          ST_DEV_ACK:
          begin
            cnt <= 4'h0;
            if (rw)
            begin
              st <= ST_RDATA;
              txsh <= rd_byte;
              SDA_OE_OUT <= ~rd_byte[7];
            end
            else
            begin
              st <= ST_SUB;
              SDA_OE_OUT <= 1'b0;
            end
          end
          ST_SUB:
          begin
            if (cnt == BITS_PER_BYTE)
            begin
              ptr <= shreg;
              st <= ST_SUB_ACK;
              SDA_OE_OUT <= 1'b1;
            end
          end
          ST_SUB_ACK, ST_WACK:
          begin
            cnt <= 4'h0;
            st <= ST_WDATA;
            SDA_OE_OUT <= 1'b0;
          end
          ST_WDATA:
          begin
            if (cnt == BITS_PER_BYTE)
            begin
              wr_pulse <= 1'b1;
              st <= ST_WACK;
              SDA_OE_OUT <= 1'b1;
            end
          end
          ST_RDATA:
          begin
            if (cnt == BITS_PER_BYTE)
            begin
              st <= ST_RACK;
              ptr <= ptr + 8'h01;
              SDA_OE_OUT <= 1'b0;
            end
            else
            begin
              txsh <= {txsh[6:0], 1'b0};
              SDA_OE_OUT <= ~txsh[6];
            end
          end
          ST_RACK:
          begin
            if (shreg[0])
            begin
              st <= ST_IDLE;
            end
            else
            begin
              st <= ST_RDATA;
              cnt <= 4'h0;
              txsh <= rd_byte;
              SDA_OE_OUT <= ~rd_byte[7];
            end
          end
          default:
          begin
            st <= ST_IDLE;
          end
        endcase
      end
      if (wr_pulse)
      begin
        ptr <= ptr + 8'h01;
      end
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      SDA_OUT <= 1'b0;
    end
    else if (CE_IN)
    begin
      SDA_OUT <= 1'b0;
    end
  end

  // ----------------------------------------
  // Writable bytes
  // ----------------------------------------
  logic soft_tx_off;
  logic soft_rx_rate;
  logic soft_tx_rate;
  logic [3:0] eq_code;
  logic [3:0] boost_code;

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      soft_tx_off <= SOFT_RESET;
      soft_rx_rate <= SOFT_RESET;
      soft_tx_rate <= SOFT_RESET;
      eq_code <= CODE_RESET;
      boost_code <= CODE_RESET;
    end
    else if (CE_IN && wr_pulse)
    begin
      case (ptr)
        OFS_SOFT_COMMAND_STATUS:
        begin
          soft_tx_off <= shreg[BIT_SOFT_TX_OFF];
          soft_rx_rate <= shreg[BIT_SOFT_RX_RATE];
        end
        OFS_EXTENDED_SOFT_CONTROL:
        begin
          soft_tx_rate <= shreg[BIT_SOFT_TX_RATE];
        end
        OFS_TX_INPUT_EQUALIZATION:
        begin
          if (shreg[CODE_MSB:CODE_LSB] <= EQ_CODE_MAX)
          begin
            eq_code <= shreg[CODE_MSB:CODE_LSB];
          end
        end
        OFS_RX_OUTPUT_EMPHASIS:
        begin
          boost_code <= shreg[CODE_MSB:CODE_LSB];
        end
        default:
        begin
          eq_code <= eq_code;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      for (int i = 0; i <= 39; i++)
      begin
        thr[i] <= THR_RESET;
      end
    end
    else if (CE_IN && wr_pulse && ptr <= THR_LAST)
    begin
      thr[ptr[5:0]] <= shreg;
    end
  end

  // ----------------------------------------
  // Control outputs
  // ----------------------------------------
  always_ff @(posedge MCLK_IN or posedge RST_IN)
  begin
    if (RST_IN)
    begin
      TX_OFF_OUT <= 1'b1;
      TX_HIGH_RATE_OUT <= 1'b0;
      RX_HIGH_RATE_OUT <= 1'b0;
      INPUT_EQUALIZER_CODE_OUT <= CODE_RESET;
      OUTPUT_BOOST_CODE_OUT <= CODE_RESET;
    end
    else if (CE_IN)
    begin
      TX_OFF_OUT <= pin_tx_off | soft_tx_off;
      TX_HIGH_RATE_OUT <= pin_tx_rate | soft_tx_rate;
      RX_HIGH_RATE_OUT <= pin_rx_rate | soft_rx_rate;
      INPUT_EQUALIZER_CODE_OUT <= eq_code;
      OUTPUT_BOOST_CODE_OUT <= boost_code;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  logic [7:0] mon_idx;
  logic [15:0] mon_sel;

  always_comb
  begin
    mon_idx = ptr - MON_FIRST;
    mon_sel = 16'h0000;
    for (int i = 0; i < NUM_MON; i++)
    begin
      if (mon_idx[3:1] == i[2:0])
      begin
        mon_sel = mon[i];
      end
    end
    rd_byte = 8'h00;
    if (ptr <= THR_LAST)
    begin
      rd_byte = thr[ptr[5:0]];
    end
    else if (ptr >= CAL_FIRST && ptr <= CAL_LAST)
    begin
      rd_byte = CAL_DEFAULT;
    end
    else if (ptr == OFS_CHECKSUM)
    begin
      rd_byte = CHECKSUM_DEFAULT;
    end
    else if (ptr >= MON_FIRST && ptr <= MON_LAST)
    begin
      rd_byte = mon_idx[0] ? mon_sel[7:0] : mon_sel[15:8];
    end
    else
    begin
      case (ptr)
        OFS_SOFT_COMMAND_STATUS:
        begin
          rd_byte[BIT_TX_OFF_PIN] = pin_tx_off;
          rd_byte[BIT_SOFT_TX_OFF] = soft_tx_off;
          rd_byte[BIT_TX_RATE_PIN] = pin_tx_rate;
          rd_byte[BIT_RX_RATE_PIN] = pin_rx_rate;
          rd_byte[BIT_SOFT_RX_RATE] = soft_rx_rate;
          rd_byte[BIT_TX_FAULT] = TX_FAULT_IN;
          rd_byte[BIT_SIGNAL_LOSS] = SIGNAL_LOSS_OUTPUT_IN;
          rd_byte[BIT_READY_N] = ~MON_VALID_IN;
        end
        OFS_ALARM_FLAGS_A: rd_byte = alarm[9:2];
        OFS_ALARM_FLAGS_B: rd_byte = {alarm[1:0], 6'h00};
        OFS_WARNING_FLAGS_A: rd_byte = warn[9:2];
        OFS_WARNING_FLAGS_B: rd_byte = {warn[1:0], 6'h00};
        OFS_TX_INPUT_EQUALIZATION: rd_byte = {eq_code, 4'h0};
        OFS_RX_OUTPUT_EMPHASIS: rd_byte = {boost_code, 4'h0};
        OFS_EXTENDED_SOFT_CONTROL:
        begin
          rd_byte[BIT_SOFT_TX_RATE] = soft_tx_rate;
          rd_byte[BIT_POWER_STATE] = 1'b0;
        end
        OFS_CLOCK_RECOVERY_LOCK_STATUS:
        begin
          rd_byte[BIT_TX_LOCK_LOST] = TX_LOCK_LOST_FLAG_IN;
          rd_byte[BIT_RX_LOCK_LOST] = RX_LOCK_LOST_FLAG_IN;
        end
        default: rd_byte = 8'h00;
      endcase
    end
  end

endmodule

// ### verification/diag_bank_monitor.sv
module diag_bank_monitor
  import diag_bank_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RST_IN,
  input wire logic CE_IN,
  input wire logic SDA_OE_OUT,
  input wire logic TX_OFF_PIN_IN,
  input wire logic TRANSMIT_RATE_CHOICE_IN,
  input wire logic RECEIVE_RATE_CHOICE_IN,
  input wire logic TX_OFF_OUT,
  input wire logic TX_HIGH_RATE_OUT,
  input wire logic RX_HIGH_RATE_OUT,
  input wire logic [3:0] INPUT_EQUALIZER_CODE_OUT,
  input wire logic [3:0] OUTPUT_BOOST_CODE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (RST_IN || !CE_IN);
  // ----------------
  // Sequences
  // ----------------
  sequence held_s(sig);
    sig [*6];
  endsequence
  sequence ack_s;
    ##[0:8] SDA_OE_OUT;
  endsequence
  // ----------------
  // Checks
  // ----------------
  tx_off_pin_a: assert property (held_s(TX_OFF_PIN_IN) |-> TX_OFF_OUT)
    else $error("tx on with pin held");
  rx_rate_pin_a: assert property (held_s(RECEIVE_RATE_CHOICE_IN) |-> RX_HIGH_RATE_OUT)
    else $error("rx rate low with pin held");
  tx_rate_pin_a: assert property (held_s(TRANSMIT_RATE_CHOICE_IN) |-> TX_HIGH_RATE_OUT)
    else $error("tx rate low with pin held");
  reset_safe_a: assert property (disable iff (1'b0) RST_IN [*2] |-> !TX_HIGH_RATE_OUT && !RX_HIGH_RATE_OUT)
    else $error("rate high in reset");
  eq_range_a: assert property (INPUT_EQUALIZER_CODE_OUT <= EQ_CODE_MAX)
    else $error("equalizer code out of range");
  eq_commit_a: assert property ($changed(INPUT_EQUALIZER_CODE_OUT) |-> ack_s)
    else $error("equalizer change outside write");
  boost_commit_a: assert property ($changed(OUTPUT_BOOST_CODE_OUT) |-> ack_s)
    else $error("boost change outside write");
  tx_off_release_a: assert property ($fell(TX_OFF_OUT) |-> !$past(TX_OFF_PIN_IN, 2) || !$past(TX_OFF_PIN_IN, 3))
    else $error("tx on while pin high");
endmodule

bind diag_bank diag_bank_monitor mon_u (
  .MCLK_IN(MCLK_IN),
  .RST_IN(RST_IN),
  .CE_IN(CE_IN),
  .SDA_OE_OUT(SDA_OE_OUT),
  .TX_OFF_PIN_IN(TX_OFF_PIN_IN),
  .TRANSMIT_RATE_CHOICE_IN(TRANSMIT_RATE_CHOICE_IN),
  .RECEIVE_RATE_CHOICE_IN(RECEIVE_RATE_CHOICE_IN),
  .TX_OFF_OUT(TX_OFF_OUT),
  .TX_HIGH_RATE_OUT(TX_HIGH_RATE_OUT),
  .RX_HIGH_RATE_OUT(RX_HIGH_RATE_OUT),
  .INPUT_EQUALIZER_CODE_OUT(INPUT_EQUALIZER_CODE_OUT),
  .OUTPUT_BOOST_CODE_OUT(OUTPUT_BOOST_CODE_OUT)
);

// ### verification/diag_host_model.sv
module diag_host_model
  import diag_bank_pkg::*;
(
  input wire logic mclk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull,
  output logic [7:0] rd_byte,
  output logic rd_stb
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------
  // Two-wire master, 160 ns bit period
  // ----------------
  initial
  begin
    scl = 1'b1;
    sda_pull = 1'b0;
    rd_byte = 8'h00;
    rd_stb = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic start();
    sda_pull = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_pull = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    sda_pull = 1'b0;
    tick(4);
  endtask
  task automatic xbit(input logic b, output logic s);
    tick(2);
    sda_pull = !b;
    tick(2);
    scl = 1'b1;
    tick(2);
    s = sda_line;
    tick(2);
    scl = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] b, input logic ab, output logic [7:0] s, output logic a);
    logic bs;
    for (int i = 7; i >= 0; i--)
    begin
      xbit(b[i], bs);
      s[i] = bs;
    end
    xbit(ab, a);
  endtask
  task automatic wr(input logic [7:0] dev, input logic [7:0] ptr, input logic [7:0] data[$], output logic ok);
    logic [7:0] s;
    logic a;
    start();
    xbyte(dev, 1'b1, s, a);
    ok = !a;
    xbyte(ptr, 1'b1, s, a);
    ok &= !a;
    foreach (data[i])
    begin
      xbyte(data[i], 1'b1, s, a);
      ok &= !a;
    end
    stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input int n);
    logic [7:0] s;
    logic a;
    start();
    xbyte({DEV_ADDR, 1'b0}, 1'b1, s, a);
    xbyte(ptr, 1'b1, s, a);
    start();
    xbyte({DEV_ADDR, 1'b1}, 1'b1, s, a);
    for (int i = 0; i < n; i++)
    begin
      xbyte(8'hff, i == n - 1, s, a);
      rd_byte = s;
      rd_stb = 1'b1;
      tick(1);
      rd_stb = 1'b0;
    end
    stop();
  endtask
endmodule

// ### verification/diag_bank_tb.sv
`define CHK(a, e) \
  begin \
    n_compared++; \
    if ((a) !== (e)) \
    begin \
      n_mismatch++; \
      $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); \
    end \
  end

module diag_bank_tb
  import diag_bank_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst, tx_off_pin, tx_rate, rx_rate, fault, loss, mon_valid, tx_lol, rx_lol;
  logic scl, host_pull, sda_oe, rd_stb, tx_off, tx_hi, rx_hi, ok, ce, sda_out;
  logic [15:0] mon [5];
  logic [15:0] cv [3] = '{16'h4000, 16'h1000, 16'hf000};
  logic [3:0] f [5];
  logic [7:0] rd_byte, exp_b;
  logic [3:0] eq_code, boost;
  logic [7:0] exp_q[$];
  logic [7:0] d[$];
  int n_mismatch = 0;
  int n_compared = 0;
  int seed = 32'h2a3e;
  wire sda_line = !(host_pull | sda_oe);

  diag_bank dut_u (
    .MCLK_IN(mclk), .RST_IN(rst), .CE_IN(ce), .SCL_IN(scl), .SDA_IN(sda_line),
    .SDA_OUT(sda_out), .SDA_OE_OUT(sda_oe), .TX_OFF_PIN_IN(tx_off_pin),
    .TRANSMIT_RATE_CHOICE_IN(tx_rate), .RECEIVE_RATE_CHOICE_IN(rx_rate), .TX_FAULT_IN(fault),
    .SIGNAL_LOSS_OUTPUT_IN(loss), .MON_VALID_IN(mon_valid), .TX_LOCK_LOST_FLAG_IN(tx_lol),
    .RX_LOCK_LOST_FLAG_IN(rx_lol), .MON_TEMP_IN(mon[0]), .MON_VCC_IN(mon[1]), .MON_BIAS_IN(mon[2]),
    .MON_TX_POWER_IN(mon[3]), .MON_RX_POWER_IN(mon[4]), .TX_OFF_OUT(tx_off), .TX_HIGH_RATE_OUT(tx_hi),
    .RX_HIGH_RATE_OUT(rx_hi), .INPUT_EQUALIZER_CODE_OUT(eq_code), .OUTPUT_BOOST_CODE_OUT(boost)
  );
  diag_host_model host_u (
    .mclk(mclk), .sda_line(sda_line), .scl(scl), .sda_pull(host_pull), .rd_byte(rd_byte), .rd_stb(rd_stb)
  );

  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // ----------------
  // Helpers
  // ----------------
  function automatic logic [3:0] flg(input logic [15:0] v, input logic s);
    int x;
    x = s ? int'($signed(v)) : int'(v);
    return {x > 16'sh4000, x < 16'sh1000, x > 16'sh3000, x < 16'sh2000};
  endfunction
  task automatic w(input logic [7:0] ptr, input logic [7:0] data[$]);
    host_u.wr({DEV_ADDR, 1'b0}, ptr, data, ok);
    `CHK(ok, 1'b1)
  endtask
  task automatic stop_test();
    if (exp_q.size() != 0)
      n_mismatch++;
    $display("mismatches %0d compared %0d", n_mismatch, n_compared);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge rd_stb)
  begin
    exp_b = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hxx;
    `CHK(rd_byte, exp_b)
  end
  initial
  begin
    #1_500_000;
    n_mismatch++;
    stop_test();
  end
  // ----------------
  // Scenarios
  // ----------------
  initial
  begin
    {rst, tx_off_pin, tx_rate, rx_rate, fault, loss, mon_valid, tx_lol, rx_lol} = 9'h100;
    ce = 1'b1;
    foreach (mon[i])
      mon[i] = 16'h0000;
    repeat (8) @(negedge mclk);
    `CHK(tx_off, 1'b1)
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    `CHK(tx_off, 1'b0)
    `CHK({tx_hi, rx_hi}, 2'b00)
    exp_q.push_back(8'h01);
    host_u.rd(OFS_SOFT_COMMAND_STATUS, 1);
    mon_valid = 1'b1;
    exp_q.push_back(8'h00);
    host_u.rd(OFS_SOFT_COMMAND_STATUS, 1);
    repeat (4)
    begin
      tx_off_pin = 1'($random(seed));
      tx_rate = 1'($random(seed));
      rx_rate = 1'($random(seed));
      fault = 1'($random(seed));
      loss = 1'($random(seed));
      mon_valid = 1'($random(seed));
      exp_q.push_back({tx_off_pin, 1'b0, tx_rate, rx_rate, 1'b0, fault, loss, ~mon_valid});
      host_u.rd(OFS_SOFT_COMMAND_STATUS, 1);
      `CHK(tx_off, tx_off_pin)
      `CHK(rx_hi, rx_rate)
      `CHK(tx_hi, tx_rate)
    end
    {tx_off_pin, tx_rate, rx_rate, fault, loss} = 5'h00;
    mon_valid = 1'b1;
    `CHK(sda_out, 1'b0)
    // ----------------
    // Clock enable low freezes pin path
    // ----------------
    repeat (4) @(negedge mclk);
    ce = 1'b0;
    tx_off_pin = 1'b1;
    repeat (6) @(negedge mclk);
    `CHK(tx_off, 1'b0)
    ce = 1'b1;
    repeat (4) @(negedge mclk);
    `CHK(tx_off, 1'b1)
    tx_off_pin = 1'b0;
    repeat (4) @(negedge mclk);
    `CHK(tx_off, 1'b0)
    w(OFS_SOFT_COMMAND_STATUS, '{8'h48});
    `CHK({tx_off, rx_hi}, 2'b11)
    w(OFS_EXTENDED_SOFT_CONTROL, '{8'hff});
    `CHK(tx_hi, 1'b1)
    exp_q.push_back(8'h48);
    host_u.rd(OFS_SOFT_COMMAND_STATUS, 1);
    exp_q.push_back(8'h08);
    host_u.rd(OFS_EXTENDED_SOFT_CONTROL, 1);
    w(OFS_SOFT_COMMAND_STATUS, '{8'h00});
    w(OFS_EXTENDED_SOFT_CONTROL, '{8'h00});
    `CHK({tx_off, rx_hi, tx_hi}, 3'b000)
    for (int i = 0; i < 16; i++)
    begin
      w(OFS_TX_INPUT_EQUALIZATION, '{{4'(i), 4'h0}, {4'(i), 4'h0}});
      `CHK(eq_code, (i <= 10) ? 4'(i) : 4'ha)
      `CHK(boost, 4'(i))
    end
    w(OFS_CLOCK_RECOVERY_LOCK_STATUS, '{8'hff});
    {tx_lol, rx_lol} = 2'b10;
    exp_q.push_back(8'h02);
    host_u.rd(OFS_CLOCK_RECOVERY_LOCK_STATUS, 1);
    exp_q.push_back(CAL_DEFAULT);
    exp_q.push_back(CHECKSUM_DEFAULT);
    exp_q.push_back(8'h00);
    host_u.rd(CAL_LAST, 2);
    host_u.rd(8'h78, 1);
    host_u.wr(8'ha4, 8'h00, '{8'h00}, ok);
    `CHK(ok, 1'b0)
    d = {};
    repeat (5)
      d = {d, 8'h40, 8'h00, 8'h10, 8'h00, 8'h30, 8'h00, 8'h20, 8'h00};
    w(8'h00, d);
    for (int k = 0; k < 6; k++)
    begin
      tx_lol = 1'($random(seed));
      rx_lol = 1'($random(seed));
      foreach (mon[i])
      begin
        mon[i] = (k < 3) ? cv[k] : 16'($random(seed));
        f[i] = flg(mon[i], i == 0);
        exp_q.push_back(mon[i][15:8]);
        exp_q.push_back(mon[i][7:0]);
      end
      repeat (4)
        exp_q.push_back(8'h00);
      exp_q.push_back(8'h00);
      exp_q.push_back(8'h00);
      exp_q.push_back({f[0][3:2], f[1][3:2], f[2][3:2], f[3][3:2]});
      exp_q.push_back({f[4][3:2], 6'h00});
      exp_q.push_back(8'ha0);
      exp_q.push_back(8'hf0);
      exp_q.push_back({f[0][1:0], f[1][1:0], f[2][1:0], f[3][1:0]});
      exp_q.push_back({f[4][1:0], 6'h00});
      exp_q.push_back(8'h00);
      exp_q.push_back({6'h00, tx_lol, rx_lol});
      host_u.rd(MON_FIRST, 24);
    end
    rst = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK({tx_off, eq_code}, 5'h10)
    rst = 1'b0;
    repeat (4) @(negedge mclk);
    exp_q.push_back(THR_RESET);
    host_u.rd(8'h00, 1);
    stop_test();
  end
endmodule
